// *** design/tmr_defines.svh ***
// Constants of the 8-bit timer waveform control block.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define TMR_AW            3
`define TMR_A_WOC         3'h0
`define TMR_A_CTLB        3'h1
`define TMR_A_CNT         3'h2
`define TMR_A_CMPA        3'h3
`define TMR_A_CMPB        3'h4
`define TMR_A_FLAG        3'h5
`define TMR_A_MASK        3'h6
`define TMR_WOC_RST       8'h00
`define TMR_WOC_WMASK     8'hf3
`define TMR_CA_HI         7
`define TMR_CA_LO         6
`define TMR_CB_HI         5
`define TMR_CB_LO         4
`define TMR_WM_HI         1
`define TMR_WM_LO         0
`define TMR_CB_FRC_A      7
`define TMR_CB_FRC_B      6
`define TMR_CB_WM2        3
`define TMR_CB_ASYNC      1
`define TMR_CB_RUN        0
`define TMR_FL_WRAP       0
`define TMR_FL_MA         1
`define TMR_FL_MB         2
`define TMR_FL_MASK       3'h7
`define TMR_MAX           8'hff
`define TMR_BOTTOM        8'h00
`define TMR_MODE_NORM     3'h0
`define TMR_MODE_PC_FF    3'h1
`define TMR_MODE_CTC      3'h2
`define TMR_MODE_FAST_FF  3'h3
`define TMR_MODE_RSV4     3'h4
`define TMR_MODE_PC_A     3'h5
`define TMR_MODE_RSV6     3'h6
`define TMR_MODE_FAST_A   3'h7
`define TMR_ACT_OFF       2'h0
`define TMR_ACT_TGL       2'h1
`define TMR_ACT_CLR       2'h2
`define TMR_ACT_SET       2'h3
`endif

// *** design/tmr_pkg.sv ***
// Types shared by the timer waveform control modules.
package tmr_pkg;
    // Waveform class derived from the mode field.
    typedef enum logic [2:0] {
        TMR_CLS_PLAIN = 3'b001,
        TMR_CLS_FAST  = 3'b010,
        TMR_CLS_PC    = 3'b100
    } tmr_cls_t;
endpackage

// *** design/tmr_timing_if.sv ***
// Counter timing events shared by both compare channels.
`timescale 1ns/1ns
interface tmr_timing_if;
    import tmr_pkg::*;
    logic     tick;
    logic     at_top;
    logic     down;
    logic     top_bit;
    tmr_cls_t cls;
    modport src (output tick, at_top, down, top_bit, cls);
    modport chan (input tick, at_top, down, top_bit, cls);
endinterface

// *** design/tmr_wave_chan.sv ***
// One compare channel: waveform output register and its actions.
`timescale 1ns/1ns
`include "tmr_defines.svh"
module tmr_wave_chan
    import tmr_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // Shared counter timing.
    tmr_timing_if.chan      tm,
    // Channel controls.
    input  wire logic [1:0] i_act,
    input  wire logic       i_match,
    input  wire logic       i_cmp_eq_top,
    input  wire logic       i_force,
    input  wire logic       i_is_b,
    // Waveform level.
    output logic            o_wave
);
    logic wave_r;
    logic wave_nxt;
    logic hit;

    assign o_wave = wave_r;

    // Decide the next waveform level from mode, action and events.
    always_comb begin
        wave_nxt = wave_r;
        hit      = i_match && tm.tick;
        unique case (tm.cls)
            TMR_CLS_PLAIN: begin
                if (hit || i_force) begin
                    unique case (i_act)
                        `TMR_ACT_TGL: wave_nxt = ~wave_r;
                        `TMR_ACT_CLR: wave_nxt = 1'b0;
                        `TMR_ACT_SET: wave_nxt = 1'b1;
                        `TMR_ACT_OFF: wave_nxt = wave_r;
                    endcase
                end
            end
            TMR_CLS_FAST: begin
                if (i_act == `TMR_ACT_TGL) begin
                    if (hit && tm.top_bit && !i_is_b) begin
                        wave_nxt = ~wave_r;
                    end
                end else if (i_act[1]) begin
                    // A match at TOP is dropped so the TOP action wins.
                    if (tm.tick && tm.at_top) begin
                        wave_nxt = ~i_act[0];
                    end else if (hit && !i_cmp_eq_top) begin
                        wave_nxt = i_act[0];
                    end
                end
            end
            TMR_CLS_PC: begin
                if (i_act == `TMR_ACT_TGL) begin
                    if (hit && tm.top_bit && !i_is_b) begin
                        wave_nxt = ~wave_r;
                    end
                end else if (i_act[1]) begin
                    if (i_cmp_eq_top) begin
                        if (tm.tick && tm.at_top) begin
                            wave_nxt = ~i_act[0];
                        end
                    end else if (hit) begin
                        wave_nxt = tm.down ? ~i_act[0] : i_act[0];
                    end
                end
            end
        endcase
    end

    // Waveform register.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wave_r <= 1'b0;
        end else begin
            wave_r <= wave_nxt;
        end
    end
endmodule

// *** design/tmr_top.sv ***
// Top of the 8-bit timer with mode control and two compare channels.
`timescale 1ns/1ns
`include "tmr_defines.svh"
module tmr_top
    import tmr_pkg::*;
(
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    // Register port.
    input  wire logic [`TMR_AW-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [7:0]             o_rdata,
    // Timer oscillator and vector acknowledges.
    input  wire logic              i_osc,
    input  wire logic [2:0]        i_vec_ack,
    // Normal port function of the two pins.
    input  wire logic              i_port_a_data,
    input  wire logic              i_port_a_dir,
    input  wire logic              i_port_b_data,
    input  wire logic              i_port_b_dir,
    // Waveform pins and interrupt.
    output logic                   o_chan_a_wave_pin,
    output logic                   o_chan_a_wave_pin_oe,
    output logic                   o_chan_b_wave_pin,
    output logic                   o_chan_b_wave_pin_oe,
    output logic                   o_irq
);
    // Control and data registers.
    logic [7:0] waveform_output_control_r;
    logic       wave_mode_top_bit_r;
    logic       async_sel_r;
    logic       run_r;
    logic [7:0] count_value_r;
    logic [7:0] cmp_a_buf_r;
    logic [7:0] cmp_b_buf_r;
    logic [7:0] cmp_a_r;
    logic [7:0] cmp_b_r;
    logic [2:0] flag_r;
    logic [2:0] mask_r;
    logic [7:0] rdata_r;
    logic       irq_r;
    logic       down_r;
    logic       blk_r;
    logic       pin_a_r;
    logic       pin_a_oe_r;
    logic       pin_b_r;
    logic       pin_b_oe_r;
    // Oscillator synchroniser and edge state.
    logic       osc_s1_r;
    logic       osc_s2_r;
    logic       osc_s3_r;
    logic       osc_lvl_r;
    // Decoded signals.
    logic [2:0] mode;
    logic [1:0] chan_a_output_action;
    logic [1:0] chan_b_output_action;
    logic       timer_tick_enable;
    logic       osc_rise;
    logic [7:0] top_val;
    logic       at_top;
    logic       match_a;
    logic       match_b;
    logic       wrap_evt;
    logic       upd_now;
    logic       wr_cnt;
    logic [7:0] cnt_nxt;
    logic       down_nxt;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic       frc_a;
    logic       frc_b;
    logic       wave_a;
    logic       wave_b;
    logic       conn_a;
    tmr_cls_t   cls;

    tmr_timing_if tm ();

    assign o_rdata              = rdata_r;
    assign o_irq                = irq_r;
    assign o_chan_a_wave_pin    = pin_a_r;
    assign o_chan_a_wave_pin_oe = pin_a_oe_r;
    assign o_chan_b_wave_pin    = pin_b_r;
    assign o_chan_b_wave_pin_oe = pin_b_oe_r;

    // Mode field spans two registers.
    assign mode = {wave_mode_top_bit_r,
        waveform_output_control_r[`TMR_WM_HI:`TMR_WM_LO]};
    assign chan_a_output_action =
        waveform_output_control_r[`TMR_CA_HI:`TMR_CA_LO];
    assign chan_b_output_action =
        waveform_output_control_r[`TMR_CB_HI:`TMR_CB_LO];

    // Mode decode; reserved codes fall back to plain counting.
    always_comb begin
        cls     = TMR_CLS_PLAIN;
        top_val = `TMR_MAX;
        upd_now = 1'b1;
        unique case (mode)
            `TMR_MODE_PC_FF: begin
                cls     = TMR_CLS_PC;
                upd_now = 1'b0;
            end
            `TMR_MODE_CTC: begin
                top_val = cmp_a_r;
            end
            `TMR_MODE_FAST_FF: begin
                cls     = TMR_CLS_FAST;
                upd_now = 1'b0;
            end
            `TMR_MODE_PC_A: begin
                cls     = TMR_CLS_PC;
                top_val = cmp_a_r;
                upd_now = 1'b0;
            end
            `TMR_MODE_FAST_A: begin
                cls     = TMR_CLS_FAST;
                top_val = cmp_a_r;
                upd_now = 1'b0;
            end
            default: begin
                cls     = TMR_CLS_PLAIN;
                top_val = `TMR_MAX;
                upd_now = 1'b1;
            end
        endcase
    end

    // Oscillator pin passes three flops; a rising edge counts once stages agree.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            osc_s1_r  <= 1'b0;
            osc_s2_r  <= 1'b0;
            osc_s3_r  <= 1'b0;
            osc_lvl_r <= 1'b0;
        end else begin
            osc_s1_r <= i_osc;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
            if (osc_s2_r == osc_s3_r) begin
                osc_lvl_r <= osc_s3_r;
            end
        end
    end

    assign osc_rise = (osc_s2_r == osc_s3_r) && osc_s3_r && !osc_lvl_r;
    // Synchronous mode ticks every I/O clock; prescaling lies upstream.
    assign timer_tick_enable = run_r &&
        (async_sel_r ? osc_rise : 1'b1);

    assign at_top   = (count_value_r == top_val);
    assign wr_cnt   = i_wr && (i_addr == `TMR_A_CNT);
    // A software write to the counter hides the match on the next tick.
    assign match_a  = (count_value_r == cmp_a_r) && !blk_r;
    assign match_b  = (count_value_r == cmp_b_r) && !blk_r;
    assign frc_a    = i_wr && (i_addr == `TMR_A_CTLB) &&
        i_wdata[`TMR_CB_FRC_A] && (cls == TMR_CLS_PLAIN);
    assign frc_b    = i_wr && (i_addr == `TMR_A_CTLB) &&
        i_wdata[`TMR_CB_FRC_B] && (cls == TMR_CLS_PLAIN);

    // Next count value and direction.
    always_comb begin
        cnt_nxt  = count_value_r;
        down_nxt = down_r;
        wrap_evt = 1'b0;
        if (timer_tick_enable) begin
            unique case (cls)
                TMR_CLS_PC: begin
                    if (!down_r) begin
                        if (at_top) begin
                            down_nxt = 1'b1;
                            cnt_nxt  = count_value_r - 8'h01;
                        end else begin
                            cnt_nxt  = count_value_r + 8'h01;
                        end
                    end else if (count_value_r == `TMR_BOTTOM) begin
                        down_nxt = 1'b0;
                        cnt_nxt  = count_value_r + 8'h01;
                        wrap_evt = 1'b1;
                    end else begin
                        cnt_nxt  = count_value_r - 8'h01;
                    end
                end
                default: begin
                    down_nxt = 1'b0;
                    if (at_top) begin
                        cnt_nxt = `TMR_BOTTOM;
                    end else begin
                        cnt_nxt = count_value_r + 8'h01;
                    end
                    if (mode == `TMR_MODE_FAST_A) begin
                        wrap_evt = at_top;
                    end else begin
                        wrap_evt = (count_value_r == `TMR_MAX);
                    end
                end
            endcase
        end
    end

    // Counter, direction and match blanking.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            count_value_r <= `TMR_BOTTOM;
            down_r        <= 1'b0;
            blk_r         <= 1'b0;
        end else begin
            down_r <= down_nxt;
            if (wr_cnt) begin
                count_value_r <= i_wdata;
                blk_r         <= 1'b1;
            end else begin
                count_value_r <= cnt_nxt;
                if (timer_tick_enable) begin
                    blk_r <= 1'b0;
                end
            end
        end
    end

    // Software writes of control registers and compare buffers.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            waveform_output_control_r <= `TMR_WOC_RST;
            wave_mode_top_bit_r       <= 1'b0;
            async_sel_r               <= 1'b0;
            run_r                     <= 1'b0;
            cmp_a_buf_r               <= `TMR_BOTTOM;
            cmp_b_buf_r               <= `TMR_BOTTOM;
            mask_r                    <= 3'h0;
        end else if (i_wr) begin
            unique case (i_addr)
                `TMR_A_WOC: waveform_output_control_r <=
                    i_wdata & `TMR_WOC_WMASK;
                `TMR_A_CTLB: begin
                    wave_mode_top_bit_r <= i_wdata[`TMR_CB_WM2];
                    async_sel_r         <= i_wdata[`TMR_CB_ASYNC];
                    run_r               <= i_wdata[`TMR_CB_RUN];
                end
                `TMR_A_CMPA: cmp_a_buf_r <= i_wdata;
                `TMR_A_CMPB: cmp_b_buf_r <= i_wdata;
                `TMR_A_MASK: mask_r      <= i_wdata[2:0];
                default: ;
            endcase
        end
    end

    // Active compare values: direct in plain modes, at TOP in PWM.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cmp_a_r <= `TMR_BOTTOM;
            cmp_b_r <= `TMR_BOTTOM;
        end else if (upd_now || (timer_tick_enable && at_top)) begin
            cmp_a_r <= cmp_a_buf_r;
            cmp_b_r <= cmp_b_buf_r;
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle.
    assign flag_set = {match_b && timer_tick_enable,
                       match_a && timer_tick_enable, wrap_evt};
    assign flag_clr = i_vec_ack |
        ((i_wr && i_addr == `TMR_A_FLAG) ? i_wdata[2:0] : 3'h0);

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            flag_r <= 3'h0;
            irq_r  <= 1'b0;
        end else begin
            flag_r <= (flag_r & ~flag_clr) | flag_set;
            irq_r  <= |(((flag_r & ~flag_clr) | flag_set) & mask_r);
        end
    end

    // Timing shared with the channel units.
    assign tm.tick    = timer_tick_enable;
    assign tm.at_top  = at_top;
    assign tm.down    = down_r;
    assign tm.top_bit = wave_mode_top_bit_r;
    assign tm.cls     = cls;

    tmr_wave_chan u_chan_a (
        .i_clk        (i_clk),
        .i_rst_b      (i_rst_b),
        .tm           (tm),
        .i_act        (chan_a_output_action),
        .i_match      (match_a),
        .i_cmp_eq_top (cmp_a_r == top_val),
        .i_force      (frc_a),
        .i_is_b       (1'b0),
        .o_wave       (wave_a)
    );

    tmr_wave_chan u_chan_b (
        .i_clk        (i_clk),
        .i_rst_b      (i_rst_b),
        .tm           (tm),
        .i_act        (chan_b_output_action),
        .i_match      (match_b),
        .i_cmp_eq_top (cmp_b_r == top_val),
        .i_force      (frc_b),
        .i_is_b       (1'b1),
        .o_wave       (wave_b)
    );

    // PWM toggle without the top mode bit leaves pin A to the port.
    assign conn_a = (|chan_a_output_action) && !(cls != TMR_CLS_PLAIN &&
        chan_a_output_action == `TMR_ACT_TGL && !wave_mode_top_bit_r);

    // Pin mux: a connected action field steals the pin from the port.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pin_a_r    <= 1'b0;
            pin_a_oe_r <= 1'b0;
            pin_b_r    <= 1'b0;
            pin_b_oe_r <= 1'b0;
        end else begin
            pin_a_r    <= conn_a ? wave_a : i_port_a_data;
            pin_b_r    <= (|chan_b_output_action) ? wave_b
                                                  : i_port_b_data;
            // The driver only follows the direction bit.
            pin_a_oe_r <= i_port_a_dir;
            pin_b_oe_r <= i_port_b_dir;
        end
    end

    // Read data, valid the cycle after the strobe.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rdata_r <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                `TMR_A_WOC:  rdata_r <= waveform_output_control_r;
                `TMR_A_CTLB: rdata_r <= {4'h0, wave_mode_top_bit_r, 1'b0,
                                         async_sel_r, run_r};
                `TMR_A_CNT:  rdata_r <= count_value_r;
                `TMR_A_CMPA: rdata_r <= cmp_a_buf_r;
                `TMR_A_CMPB: rdata_r <= cmp_b_buf_r;
                `TMR_A_FLAG: rdata_r <= {5'h00, flag_r};
                `TMR_A_MASK: rdata_r <= {5'h00, mask_r};
                default:     rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
endmodule

// *** tb/tmr_top_sva.sv ***
// Port-level checker for the timer top, bound into it.
`timescale 1ns/1ns
`include "tmr_defines.svh"
module tmr_top_sva (
    // Clock and reset.
    input wire logic               i_clk,
    input wire logic               i_rst_b,
    // Register port.
    input wire logic [`TMR_AW-1:0] i_addr,
    input wire logic [7:0]         i_wdata,
    input wire logic               i_wr,
    input wire logic               i_rd,
    input wire logic [7:0]         o_rdata,
    // Pins and interrupt.
    input wire logic               i_port_a_data,
    input wire logic               i_port_a_dir,
    input wire logic               i_port_b_data,
    input wire logic               i_port_b_dir,
    input wire logic               o_chan_a_wave_pin,
    input wire logic               o_chan_a_wave_pin_oe,
    input wire logic               o_chan_b_wave_pin,
    input wire logic               o_chan_b_wave_pin_oe,
    input wire logic               o_irq
);
    logic [7:0] woc_r;
    logic [3:0] ctl_r;
    logic [2:0] msk_r;
    // Shadows of the written controls; force bits are strobes, not kept.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            woc_r <= 8'h00;
            ctl_r <= 4'h0;
            msk_r <= 3'h0;
        end else if (i_wr) begin
            if (i_addr == `TMR_A_WOC) woc_r <= i_wdata & 8'hf3;
            if (i_addr == `TMR_A_CTLB) ctl_r <= i_wdata[3:0] & 4'hb;
            if (i_addr == `TMR_A_MASK) msk_r <= i_wdata[2:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Two back-to-back count reads in synchronous normal mode.
    property p_count_step;
        $past(i_rd) && $past(i_rd, 2) && $past(i_addr) == `TMR_A_CNT &&
        $past(i_addr, 2) == `TMR_A_CNT && $past(woc_r[1:0], 2) == 2'h0 &&
        $past(ctl_r, 2) == $past(ctl_r, 3) && $past(ctl_r[3:1], 2) == 3'h0
        |-> o_rdata == $past(o_rdata) + {7'h00, $past(ctl_r[0], 2)};
    endproperty
    a_oe_follows_dir: assert property ($past(i_rst_b) |->
        o_chan_a_wave_pin_oe == $past(i_port_a_dir) &&
        o_chan_b_wave_pin_oe == $past(i_port_b_dir))
        else $error("pin enable does not follow direction");
    a_pin_a_port: assert property ($past(i_rst_b) &&
        $past(woc_r[7:6]) == 2'h0 |-> o_chan_a_wave_pin == $past(i_port_a_data))
        else $error("pin a not on port data");
    a_pin_b_port: assert property ($past(i_rst_b) &&
        $past(woc_r[5:4]) == 2'h0 |-> o_chan_b_wave_pin == $past(i_port_b_data))
        else $error("pin b not on port data");
    a_rdata_zero: assert property ((!i_rd || i_addr == 3'h7) |=>
        o_rdata == 8'h00) else $error("read data not zero");
    a_woc_readback: assert property ($past(i_rd) &&
        $past(i_addr) == `TMR_A_WOC |-> o_rdata == $past(woc_r))
        else $error("control register read back wrong");
    a_irq_flags: assert property ($past(i_rd) &&
        $past(i_addr) == `TMR_A_FLAG |-> o_irq == |(o_rdata[2:0] & $past(msk_r)))
        else $error("interrupt disagrees with flags and mask");
    a_irq_quiet: assert property ($past(msk_r) == 3'h0 |-> !o_irq)
        else $error("interrupt while all masked");
    a_count_step: assert property (p_count_step)
        else $error("count step wrong");
    // Main scenarios reached.
    cover property ($rose(o_irq));
    cover property ($rose(o_chan_a_wave_pin) && o_chan_a_wave_pin_oe);
    cover property ($fell(o_chan_b_wave_pin));
endmodule
bind tmr_top tmr_top_sva u_sva (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_port_a_data(i_port_a_data), .i_port_a_dir(i_port_a_dir),
    .i_port_b_data(i_port_b_data), .i_port_b_dir(i_port_b_dir),
    .o_chan_a_wave_pin(o_chan_a_wave_pin),
    .o_chan_a_wave_pin_oe(o_chan_a_wave_pin_oe),
    .o_chan_b_wave_pin(o_chan_b_wave_pin),
    .o_chan_b_wave_pin_oe(o_chan_b_wave_pin_oe), .o_irq(o_irq));

// *** tb/tmr_pin_load.sv ***
// Load on one waveform pin: sees the wire and measures its pulse widths.
`timescale 1ns/1ns
module tmr_pin_load (
    // Clock and measurement clear.
    input  wire logic  i_clk,
    input  wire logic  i_clr,
    // Pin driver of the timer.
    input  wire logic  i_pin,
    input  wire logic  i_oe,
    // Wire level and measurements.
    output logic       o_level,
    output logic [15:0] o_edges,
    output logic [15:0] o_hi_w,
    output logic [15:0] o_lo_w
);
    logic        prev_r;
    logic [15:0] run_r;
    // The load pulls down, so an undriven pin never shows the last level.
    assign o_level = i_oe ? i_pin : 1'b0;
    // Width of each finished level in clock cycles.
    always_ff @(posedge i_clk) begin
        prev_r <= o_level;
        if (i_clr) begin
            o_edges <= 16'h0000;
            o_hi_w <= 16'h0000;
            o_lo_w <= 16'h0000;
            run_r <= 16'h0001;
        end else if (o_level != prev_r) begin
            o_edges <= o_edges + 16'h0001;
            if (prev_r) o_hi_w <= run_r;
            else o_lo_w <= run_r;
            run_r <= 16'h0001;
        end else begin
            run_r <= run_r + 16'h0001;
        end
    end
endmodule

// *** tb/timer8_waveform_control_tb.sv ***
// Self-checking bench for the timer waveform control top.
`timescale 1ns/1ns
module timer8_waveform_control_tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        osc = 1'b0;
    logic [2:0]  ack = 3'h0;
    logic        pad = 1'b0;
    logic        pam = 1'b0;
    logic        pbd = 1'b0;
    logic        pbm = 1'b0;
    logic        lclr = 1'b1;
    logic [7:0]  rdata, v1, v2;
    logic        pa, paoe, pb, pboe, irq, a_lvl, b_lvl;
    logic [15:0] a_edg, a_hi, a_lo, b_edg, b_hi, b_lo, e;
    int          n_fail = 0;
    int          check_count = 0;
    int          tn = 0;
    // A 100 ns clock.
    always #50 clk = ~clk;
    tmr_top DUT (
        .i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_osc(osc),
        .i_vec_ack(ack), .i_port_a_data(pad), .i_port_a_dir(pam),
        .i_port_b_data(pbd), .i_port_b_dir(pbm),
        .o_chan_a_wave_pin(pa), .o_chan_a_wave_pin_oe(paoe),
        .o_chan_b_wave_pin(pb), .o_chan_b_wave_pin_oe(pboe), .o_irq(irq));
    tmr_pin_load lda (.i_clk(clk), .i_clr(lclr), .i_pin(pa), .i_oe(paoe),
        .o_level(a_lvl), .o_edges(a_edg), .o_hi_w(a_hi), .o_lo_w(a_lo));
    tmr_pin_load ldb (.i_clk(clk), .i_clr(lclr), .i_pin(pb), .i_oe(pboe),
        .o_level(b_lvl), .o_edges(b_edg), .o_hi_w(b_hi), .o_lo_w(b_lo));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_chk(input logic [2:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, x);
    endtask
    // Two reads with no gap; the count must step by one between them.
    task automatic cstep;
        @(posedge clk);
        addr <= 3'h2;
        rd <= 1'b1;
        @(posedge clk);
        #1 v1 = rdata;
        @(posedge clk);
        rd <= 1'b0;
        #1 v2 = rdata;
        chk(v2, 8'(v1 + 8'h01));
    endtask
    // Run from count zero with fresh flags and fresh pin measurements.
    task automatic pwm_run(input logic [7:0] c, input int n);
        reg_wr(2, 8'h00);
        reg_wr(5, 8'h07);
        @(posedge clk);
        lclr <= 1'b1;
        @(posedge clk);
        lclr <= 1'b0;
        reg_wr(1, c);
        cyc(n);
        reg_wr(1, 8'h00);
    endtask
    task automatic frc_b(input logic [1:0] act, input logic x);
        reg_wr(0, {2'h1, act, 4'h2});
        reg_wr(1, 8'h40);
        cyc(3);
        chk(b_lvl, x);
    endtask
    task automatic fin;
        tn++;
        $display("test %0d done", tn);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // The whole run is near 3000 cycles; the limit allows over six times that.
    initial begin
        #2000000;
        n_fail++;
        summarize;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        pad <= 1'b1;
        cyc(3);
        chk(paoe, 0);
        chk(a_lvl, 0);
        pam <= 1'b1;
        pbm <= 1'b1;
        cyc(3);
        chk(a_lvl, 1);
        pad <= 1'b0;
        lclr <= 1'b0;
        reg_chk(0, 8'h00);
        reg_chk(5, 8'h00);
        reg_chk(6, 8'h00);
        reg_wr(0, 8'hff);
        reg_chk(0, 8'hf3);
        reg_wr(7, 8'h5a);
        reg_chk(7, 8'h00);
        fin;
        reg_wr(0, 8'h42);
        reg_wr(3, 8'h03);
        reg_wr(4, 8'h10);
        pwm_run(8'h01, 40);
        chk(a_hi, 4);
        chk(a_lo, 4);
        reg_wr(6, 8'h02);
        reg_chk(5, 8'h02);
        cyc(2);
        chk(irq, 1);
        reg_wr(6, 8'h00);
        cyc(2);
        chk(irq, 0);
        reg_wr(5, 8'h02);
        reg_chk(5, 8'h00);
        reg_wr(1, 8'h01);
        cyc(8);
        reg_wr(1, 8'h00);
        reg_chk(5, 8'h02);
        @(posedge clk);
        ack <= 3'h2;
        @(posedge clk);
        ack <= 3'h0;
        reg_chk(5, 8'h00);
        e = a_edg;
        reg_wr(1, 8'h80);
        cyc(3);
        chk(a_edg, e + 16'h0001);
        reg_chk(5, 8'h00);
        frc_b(2'h3, 1'b1);
        frc_b(2'h2, 1'b0);
        frc_b(2'h1, 1'b1);
        fin;
        reg_wr(0, 8'h02);
        reg_wr(3, 8'h40);
        reg_wr(4, 8'h80);
        reg_wr(0, 8'hb3);
        pwm_run(8'h01, 600);
        chk(a_hi, 65);
        chk(a_lo, 191);
        chk(b_hi, 127);
        chk(b_lo, 129);
        reg_chk(5, 8'h07);
        reg_wr(0, 8'h02);
        reg_wr(3, 8'hff);
        reg_wr(0, 8'h83);
        pwm_run(8'h01, 600);
        chk(a_hi, 0);
        chk(a_lvl, 1);
        fin;
        reg_wr(0, 8'h02);
        reg_wr(3, 8'h40);
        reg_wr(4, 8'h40);
        reg_wr(0, 8'hb1);
        pwm_run(8'h01, 1200);
        chk(a_hi, 128);
        chk(a_lo, 382);
        chk(b_hi, 382);
        chk(b_lo, 128);
        reg_chk(5, 8'h07);
        reg_wr(0, 8'h41);
        pad <= 1'b1;
        cyc(3);
        chk(a_lvl, 1);
        pad <= 1'b0;
        cyc(3);
        chk(a_lvl, 0);
        reg_wr(0, 8'h02);
        reg_wr(3, 8'h10);
        reg_wr(0, 8'h41);
        pwm_run(8'h09, 200);
        chk(a_hi, 32);
        chk(a_lo, 32);
        fin;
        reg_wr(0, 8'h00);
        reg_wr(1, 8'h01);
        cstep;
        reg_wr(1, 8'h09);
        cstep;
        reg_wr(1, 8'h00);
        reg_wr(2, 8'h00);
        reg_wr(1, 8'h03);
        cyc(20);
        reg_chk(2, 8'h00);
        repeat (20) begin
            cyc(4);
            osc <= ~osc;
        end
        cyc(12);
        reg_chk(2, 8'h0a);
        fin;
        summarize;
    end
endmodule
